/* File: core/gpio_port_cfg.svh */
// Constants for the general digital I/O port.
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH

// ----------------------------------------------------------------------------
// Port geometry
// ----------------------------------------------------------------------------
`define GPIO_PORT_PINS     8

// ----------------------------------------------------------------------------
// Reset values, per pin bit
// ----------------------------------------------------------------------------
`define GPIO_DIR_RESET_BIT 1'h0
`define GPIO_OUT_RESET_BIT 1'h0
`define GPIO_IN_RESET_BIT  1'h0
`define GPIO_OFF_BIT       1'h0
`define GPIO_ON_BIT        1'h1

// ----------------------------------------------------------------------------
// Synchroniser delay, in system clock periods, as seen by software
// ----------------------------------------------------------------------------
`define GPIO_READBACK_CYCLES 1

`endif

/* File: core/gpio_port_pkg.sv */
// Types shared by the general digital I/O port.
package gpio_port_pkg;

   // ----------------------------------------------------------------------------
   // Pin configuration, encoded as {direction, output}
   // ----------------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_TRISTATE   = 2'b00,
      MODE_PULLUP     = 2'b01,
      MODE_DRIVE_LOW  = 2'b10,
      MODE_DRIVE_HIGH = 2'b11
   } pin_mode_t;

endpackage

/* File: core/pin_input_sync.sv */
// Latch-plus-flop input synchroniser for one port.
module pin_input_sync #(
   parameter int PINS = 8
) (
   input  wire logic            mclk,
   input  wire logic            reset,
   input  wire logic [PINS-1:0] digitalIn,
   output logic      [PINS-1:0] syncOut
);

`include "gpio_port_cfg.svh"

   logic [PINS-1:0] latchQ;
   logic [PINS-1:0] syncOut_next;

   // ----------------------------------------------------------------------------
   // Per-pin latch, open while the clock is high, then a rising-edge flop
   // ----------------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < PINS; i = i + 1) begin : g_bit
         // Non-blocking, so the flop still takes the value held over the low phase at the edge
         // that opens the latch.
         always_latch begin
            if (mclk) begin
               latchQ[i] <= digitalIn[i];
            end
         end
      end
   endgenerate

   always_comb begin
      syncOut_next = latchQ;
      if (reset) begin
         syncOut_next = {PINS{`GPIO_IN_RESET_BIT}};
      end
   end

   always_ff @(posedge mclk) begin
      syncOut <= syncOut_next;
   end

endmodule

/* File: core/general_digital_io_port.sv */
// General digital I/O port: direction, drive, pull-up, toggle, input sync and sleep clamp.

`include "gpio_port_cfg.svh"

// How it works
// - A set direction bit makes the pin an output, a clear one an input.
// - Input pin with output bit one and pull-ups allowed gets its pull-up.
// - Pull-up stays off when output bit is zero or pin is an output.
// - Reset tri-states every pin at once, without waiting for a clock.
// - An output pin drives high for output bit one, low for zero.
// - Writing one to an input register bit flips the output bit.
// - The global pull-up disable turns every pull-up off.
// - The input register shows the synchronised pin level in every direction.
// - A high-transparent latch feeds the input register flop.
// - Pin changes reach the input register half to one and a half periods later.
// - Written output values read back one period later; software waits a cycle.
// - Deep sleep clamps each digital input to ground before the synchroniser.
// - Pins with enabled external interrupt escape the sleep clamp.
// - A high, disabled, edge-sensed interrupt pin raises its flag on wake-up.
// - The port has direction, output and input registers.
module general_digital_io_port
   import gpio_port_pkg::*;
#(
   parameter int PINS = `GPIO_PORT_PINS
) (
   input  wire logic            mclk,
   input  wire logic            reset,
   input  wire logic            dirWrite,
   input  wire logic [PINS-1:0] dirWriteData,
   input  wire logic            outWrite,
   input  wire logic [PINS-1:0] outWriteData,
   input  wire logic            inWrite,
   input  wire logic [PINS-1:0] inWriteData,
   input  wire logic            globalPullupDisable,
   input  wire logic            deepSleep,
   input  wire logic [PINS-1:0] extIntEnable,
   input  wire logic [PINS-1:0] extIntEdgeSense,
   input  wire logic [PINS-1:0] pinIn,
   output logic      [PINS-1:0] pinOut,
   output logic      [PINS-1:0] pinOe,
   output logic      [PINS-1:0] pinPullup,
   output logic      [PINS-1:0] portDirection,
   output logic      [PINS-1:0] portOutput,
   output logic      [PINS-1:0] portInput,
   output logic      [PINS-1:0] extIntWakeSet
);

   localparam logic [PINS-1:0] DIR_RESET = {PINS{`GPIO_DIR_RESET_BIT}};
   localparam logic [PINS-1:0] OUT_RESET = {PINS{`GPIO_OUT_RESET_BIT}};
   localparam logic [PINS-1:0] ALL_OFF   = {PINS{`GPIO_OFF_BIT}};

   logic [PINS-1:0] dir_reg;
   logic [PINS-1:0] dir_next;
   logic [PINS-1:0] out_reg;
   logic [PINS-1:0] out_next;
   logic [PINS-1:0] pinOut_reg;
   logic [PINS-1:0] pinOut_next;
   logic [PINS-1:0] pinOe_reg;
   logic [PINS-1:0] pinOe_next;
   logic [PINS-1:0] pullup_reg;
   logic [PINS-1:0] pullup_next;
   logic [PINS-1:0] wake_reg;
   logic [PINS-1:0] wake_next;
   logic            sleep_reg;
   logic            sleep_next;
   logic [PINS-1:0] clampOn;
   logic [PINS-1:0] digitalIn;
   logic [PINS-1:0] syncIn;

   // ----------------------------------------------------------------------------
   // Direction and output registers
   // ----------------------------------------------------------------------------
   always_comb begin
      dir_next = dir_reg;
      out_next = out_reg;
      if (dirWrite) begin
         dir_next = dirWriteData;
      end
      if (outWrite) begin
         out_next = outWriteData;
      end
      // A toggle applies on top of a plain write in the same cycle.
      if (inWrite) begin
         out_next = out_next ^ inWriteData;
      end
      if (reset) begin
         dir_next = DIR_RESET;
         out_next = OUT_RESET;
      end
   end

   always_ff @(posedge mclk) begin
      dir_reg <= dir_next;
      out_reg <= out_next;
   end

   // ----------------------------------------------------------------------------
   // Pin drive and pull-up, decoded per pin from the next register values
   // ----------------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < PINS; i = i + 1) begin : g_pin
         pin_mode_t mode;
         assign mode = pin_mode_t'({dir_next[i], out_next[i]});
         always_comb begin
            pinOe_next[i]  = `GPIO_OFF_BIT;
            pinOut_next[i] = `GPIO_OFF_BIT;
            pullup_next[i] = `GPIO_OFF_BIT;
            case (mode)
               MODE_TRISTATE: begin
                  pinOe_next[i] = `GPIO_OFF_BIT;
               end
               MODE_PULLUP: begin
                  pullup_next[i] = ~globalPullupDisable;
               end
               MODE_DRIVE_LOW: begin
                  pinOe_next[i]  = `GPIO_ON_BIT;
                  pinOut_next[i] = `GPIO_OFF_BIT;
               end
               MODE_DRIVE_HIGH: begin
                  pinOe_next[i]  = `GPIO_ON_BIT;
                  pinOut_next[i] = `GPIO_ON_BIT;
               end
               default: begin
                  pinOe_next[i] = `GPIO_OFF_BIT;
               end
            endcase
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      pinOut_reg <= pinOut_next;
      pinOe_reg  <= pinOe_next;
      pullup_reg <= pullup_next;
   end

   // ----------------------------------------------------------------------------
   // Reset gating of the pin drivers, effective even with the clock stopped
   // ----------------------------------------------------------------------------
   always_comb begin
      pinOe     = pinOe_reg & ~{PINS{reset}};
      pinPullup = pullup_reg & ~{PINS{reset}};
   end

   assign pinOut        = pinOut_reg;
   assign portDirection = dir_reg;
   assign portOutput    = out_reg;

   // ----------------------------------------------------------------------------
   // Sleep clamp ahead of the synchroniser
   // ----------------------------------------------------------------------------
   always_comb begin
      clampOn   = {PINS{deepSleep}} & ~extIntEnable;
      digitalIn = pinIn & ~clampOn;
   end

   pin_input_sync #(
      .PINS      (PINS)
   ) u_sync (
      .mclk      (mclk),
      .reset     (reset),
      .digitalIn (digitalIn),
      .syncOut   (syncIn)
   );

   // The input register shows the pin whatever its direction.
   assign portInput = syncIn;

   // ----------------------------------------------------------------------------
   // Wake-up edge created by releasing the clamp
   // ----------------------------------------------------------------------------
   always_comb begin
      sleep_next = deepSleep;
      wake_next  = ALL_OFF;
      if (sleep_reg && !deepSleep) begin
         wake_next = pinIn & ~extIntEnable & extIntEdgeSense;
      end
      if (reset) begin
         sleep_next = `GPIO_OFF_BIT;
         wake_next  = ALL_OFF;
      end
   end

   always_ff @(posedge mclk) begin
      sleep_reg <= sleep_next;
      wake_reg  <= wake_next;
   end

   assign extIntWakeSet = wake_reg;

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   sequence toggle_req_s;
      inWrite && !outWrite && !dirWrite;
   endsequence

   sequence toggle_done_s;
      portOutput == ($past(portOutput) ^ $past(inWriteData));
   endsequence

   toggle_flips_a: assert property (toggle_req_s |=> toggle_done_s)
      else $error("Input register write did not toggle the output bits.");

   dir_drives_a: assert property (##1 pinOe == portDirection)
      else $error("Pin output enable does not follow the direction bits.");

   drive_value_a: assert property (##1 ((pinOut & pinOe) == (portOutput & portDirection)))
      else $error("Driven pin level does not match the output bits.");

   pullup_rule_a: assert property (
      !$past(globalPullupDisable) && !$past(reset) |->
         pinPullup == (~portDirection & portOutput))
      else $error("Pull-up enables do not match direction and output bits.");

   pullup_global_a: assert property ($past(globalPullupDisable) && !$past(reset) |-> pinPullup == ALL_OFF)
      else $error("Pull-up active while globally disabled.");

   // The latch closes at the falling edge, so the flop value is only known from rising-edge
   // samples when the level held still over the whole previous period.
   sequence level_steady_s;
      !reset && $stable(digitalIn);
   endsequence

   sync_delay_a: assert property (level_steady_s |=> portInput == $past(digitalIn))
      else $error("Input register does not hold the pin level one period later.");

   clamp_gate_a: assert property (deepSleep |-> (digitalIn & ~extIntEnable) == ALL_OFF)
      else $error("Sleep clamp lets a disabled pin through.");

   wake_flag_a: assert property (
      $fell(deepSleep) |=> extIntWakeSet == ($past(pinIn) & ~$past(extIntEnable) & $past(extIntEdgeSense)))
      else $error("Wake-up interrupt flag set does not match the clamped pins.");

   // Reset checks opt out of the default disable, which would otherwise switch them off.
   reset_tristate_a: assert property (
      @(posedge mclk) disable iff (1'h0) reset |-> pinOe == ALL_OFF && pinPullup == ALL_OFF)
      else $error("A pin drives or pulls up during reset.");

   reset_clear_a: assert property (
      @(posedge mclk) disable iff (1'h0) reset |=> portDirection == DIR_RESET && portOutput == OUT_RESET)
      else $error("Direction or output bits not cleared by reset.");

   sync_clear_a: assert property (@(posedge mclk) disable iff (1'h0) reset |=> portInput == ALL_OFF)
      else $error("Input register not cleared by reset.");

   wake_clear_a: assert property (@(posedge mclk) disable iff (1'h0) reset |=> extIntWakeSet == ALL_OFF)
      else $error("Wake-up flag set pulses during reset.");

   // ----------------------------------------------------------------------------
   // Checks on register loads and holds
   // ----------------------------------------------------------------------------
   sequence load_toggle_s;
      outWrite && inWrite;
   endsequence

   sequence load_toggle_done_s;
      portOutput == ($past(outWriteData) ^ $past(inWriteData));
   endsequence

   sequence regs_idle_s;
      !dirWrite && !outWrite && !inWrite;
   endsequence

   load_toggle_a: assert property (load_toggle_s |=> load_toggle_done_s)
      else $error("Toggle did not apply on top of a same-cycle output write.");

   dir_load_a: assert property (dirWrite |=> portDirection == $past(dirWriteData))
      else $error("Direction bits did not take the written value.");

   out_load_a: assert property (outWrite && !inWrite |=> portOutput == $past(outWriteData))
      else $error("Output bits did not take the written value.");

   regs_hold_a: assert property (regs_idle_s |=> $stable(portDirection) && $stable(portOutput))
      else $error("Direction or output bits changed without a write.");

   // ----------------------------------------------------------------------------
   // Checks on pin drive, input path and wake-up
   // ----------------------------------------------------------------------------
   pullup_off_a: assert property (##1 (pinPullup & (portDirection | ~portOutput)) == ALL_OFF)
      else $error("Pull-up on while the output bit is zero or the pin drives.");

   pinout_idle_a: assert property (##1 (pinOut & ~pinOe) == ALL_OFF)
      else $error("Pin level set high on a pin that is not driven.");

   clamp_free_a: assert property (!deepSleep |-> digitalIn == pinIn)
      else $error("Digital input clamped while awake.");

   clamp_escape_a: assert property (deepSleep |-> (digitalIn & extIntEnable) == (pinIn & extIntEnable))
      else $error("Sleep clamp held a pin whose external interrupt is enabled.");

   wake_pulse_a: assert property (extIntWakeSet != ALL_OFF |=> extIntWakeSet == ALL_OFF)
      else $error("Wake-up flag set lasts longer than one cycle.");

   wake_quiet_a: assert property (!$fell(deepSleep) |=> extIntWakeSet == ALL_OFF)
      else $error("Wake-up flag set without a wake-up.");

endmodule

/* File: sim/board_model.sv */
// External board model that resolves the level seen on each port pin.
module board_model #(
   parameter int PINS = 8
) (
   input  wire logic            mclk,
   input  wire logic [PINS-1:0] pinOut,
   input  wire logic [PINS-1:0] pinOe,
   input  wire logic [PINS-1:0] pinPullup,
   input  wire logic [PINS-1:0] boardEn,
   input  wire logic [PINS-1:0] boardLevel,
   output logic      [PINS-1:0] pinIn
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [PINS-1:0] lastLevel = '0;

   // A floating pin shows the inverse of its last level, so a stale value never passes.
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         if (pinOe[i])
            pinIn[i] = pinOut[i];
         else if (boardEn[i])
            pinIn[i] = boardLevel[i];
         else if (pinPullup[i])
            pinIn[i] = 1'h1;
         else
            pinIn[i] = ~lastLevel[i];
      end
   end

   always_ff @(posedge mclk) begin
      lastLevel <= pinIn;
   end
endmodule

/* File: sim/tb_top.sv */
// Self-checking testbench for the general digital I/O port.
`include "gpio_port_cfg.svh"
module tb_top;
   import gpio_port_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = `GPIO_PORT_PINS;

   logic         mclk = 1'h0, reset = 1'h1, dirWrite = 1'h0, outWrite = 1'h0, inWrite = 1'h0;
   logic         globalPullupDisable = 1'h0, deepSleep = 1'h0;
   logic [P-1:0] dirWriteData = '0, outWriteData = '0, inWriteData = '0, extIntEnable = '0;
   logic [P-1:0] extIntEdgeSense = '0, boardEn = '0, boardLevel = '0, pinIn;
   logic [P-1:0] pinOut, pinOe, pinPullup, portDirection, portOutput, portInput, extIntWakeSet;
   int           failCount = 0, totalChecks = 0;

   general_digital_io_port #(.PINS(P)) dut (.mclk(mclk), .reset(reset), .dirWrite(dirWrite),
      .dirWriteData(dirWriteData), .outWrite(outWrite), .outWriteData(outWriteData), .inWrite(inWrite),
      .inWriteData(inWriteData), .globalPullupDisable(globalPullupDisable), .deepSleep(deepSleep),
      .extIntEnable(extIntEnable), .extIntEdgeSense(extIntEdgeSense), .pinIn(pinIn), .pinOut(pinOut),
      .pinOe(pinOe), .pinPullup(pinPullup), .portDirection(portDirection), .portOutput(portOutput),
      .portInput(portInput), .extIntWakeSet(extIntWakeSet));
   board_model #(.PINS(P)) board (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe), .pinPullup(pinPullup),
      .boardEn(boardEn), .boardLevel(boardLevel), .pinIn(pinIn));

   initial begin
      forever #2.5 mclk = ~mclk;
   end

   // ----------------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------------
   task automatic check(input logic [P-1:0] seen, input logic [P-1:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Issues one write cycle; en is {dir, out, in}.
   task automatic wr(input logic [2:0] en, input logic [P-1:0] d, input logic [P-1:0] t);
      @(negedge mclk);
      {dirWrite, outWrite, inWrite} = en;
      dirWriteData = d;
      outWriteData = d;
      inWriteData = t;
      @(negedge mclk);
      {dirWrite, outWrite, inWrite} = 3'h0;
   endtask

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", totalChecks, failCount);
      if (failCount == 0 && totalChecks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------------
   task automatic test_reset();
      check(portDirection, '0);
      check(portOutput, '0);
      check(pinOe | pinPullup, '0);
      $display("test_reset done");
   endtask

   // Mode order keeps single-bit steps between configurations.
   task automatic test_modes();
      pin_mode_t seq [4] = '{MODE_PULLUP, MODE_DRIVE_HIGH, MODE_DRIVE_LOW, MODE_TRISTATE};
      for (int global_pullup_disable = 0; global_pullup_disable < 2; global_pullup_disable++) begin
         @(negedge mclk);
         globalPullupDisable = global_pullup_disable[0];
         foreach (seq[k]) begin
            wr(3'h2, {P{seq[k][0]}}, '0);
            wr(3'h4, {P{seq[k][1]}}, '0);
            check(pinOe, {P{seq[k][1]}});
            check(pinOut & pinOe, {P{seq[k] == MODE_DRIVE_HIGH}});
            check(pinPullup, {P{seq[k] == MODE_PULLUP && global_pullup_disable == 0}});
         end
      end
      globalPullupDisable = 1'h0;
      $display("test_modes done");
   endtask

   task automatic test_toggle();
      wr(3'h2, 8'h0f, '0);
      wr(3'h1, '0, 8'h33);
      check(portOutput, 8'h3c);
      wr(3'h3, 8'haa, 8'h0f);
      check(portOutput, 8'ha5);
      check(portDirection, '0);
      wr(3'h2, '0, '0);
      $display("test_toggle done");
   endtask

   task automatic test_sync();
      logic [P-1:0] pat [2] = '{8'h5a, 8'ha5};
      boardEn = '1;
      foreach (pat[k]) begin
         @(negedge mclk);
         boardLevel = pat[k];
         repeat (2) @(negedge mclk);
         check(portInput, pat[k]);
      end
      boardEn = '0;
      $display("test_sync done");
   endtask

   task automatic test_readback();
      wr(3'h2, 8'hc3, '0);
      wr(3'h4, 8'hff, '0);
      @(negedge mclk);
      check(portInput, 8'hc3);
      wr(3'h6, '0, '0);
      $display("test_readback done");
   endtask

   task automatic test_sleep_wake();
      logic [P-1:0] acc = '0;
      int           cnt = 0;
      boardEn = '1;
      boardLevel = '1;
      extIntEnable = 8'h0f;
      extIntEdgeSense = 8'h33;
      deepSleep = 1'h1;
      repeat (3) @(negedge mclk);
      check(portInput, 8'h0f);
      deepSleep = 1'h0;
      repeat (4) begin
         @(negedge mclk);
         acc |= extIntWakeSet;
         cnt += (extIntWakeSet != '0);
      end
      check(acc, 8'h30);
      check(P'(cnt), P'(1));
      boardEn = '0;
      $display("test_sleep_wake done");
   endtask

   task automatic test_async_reset();
      wr(3'h2, 8'hf0, '0);
      wr(3'h4, 8'h30, '0);
      check(pinOe | pinPullup, 8'hf0);
      reset = 1'h1;
      #1;
      check(pinOe | pinPullup, '0);
      repeat (2) @(negedge mclk);
      check(portDirection | portOutput, '0);
      reset = 1'h0;
      $display("test_async_reset done");
   endtask

   // ----------------------------------------------------------------------------
   // Main sequence and hang guard
   // ----------------------------------------------------------------------------
   initial begin
      repeat (16) @(negedge mclk);
      reset = 1'h0;
      test_reset();
      test_modes();
      test_toggle();
      test_sync();
      test_readback();
      test_sleep_wake();
      test_async_reset();
      report_and_stop();
   end

   initial begin
      repeat (5000) @(posedge mclk);
      failCount++;
      $display("ERROR %0t: run did not finish in time", $time);
      report_and_stop();
   end
endmodule
